// file: design/stn_pkg.sv
// shared constants for the colour passive panel timing block
// assumes a 32-bit apb register bus and a single system clock
package stn_pkg;

  // ---------------------------------------------------------------------------
  // bus and counter types
  // ---------------------------------------------------------------------------
  typedef logic [7:0]  addr_t;
  typedef logic [31:0] word_t;
  typedef logic [10:0] cnt_t;
  typedef enum logic {ST_IDLE, ST_RUN} run_t;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam addr_t ADDR_CTRL   = 8'h00;
  localparam addr_t ADDR_HTIME  = 8'h04;
  localparam addr_t ADDR_VTIME  = 8'h08;
  localparam addr_t ADDR_ALT    = 8'h0c;
  localparam addr_t ADDR_STATUS = 8'h10;
  localparam addr_t ADDR_DATA   = 8'h14;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_WIDE_BIT  = 1;
  localparam int CTRL_BPP15_BIT = 2;
  localparam int CTRL_DIV_LSB   = 4;
  localparam int HT_DISP_LSB    = 0;
  localparam int HT_ND_LSB      = 8;
  localparam int VT_DISP_LSB    = 0;
  localparam int VT_ND_LSB      = 16;
  localparam int ALT_RATE_LSB   = 0;
  localparam int ST_LINE_LSB    = 0;
  localparam int ST_EMPTY_BIT   = 16;
  localparam int ST_FULL_BIT    = 17;
  localparam int ST_UNDER_BIT   = 18;
  localparam int ST_RUN_BIT     = 19;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [1:0] DIV_RST   = 2'h0;
  localparam logic [6:0] HDISP_RST = 7'h27;
  localparam logic [4:0] HND_RST   = 5'h03;
  localparam logic [9:0] VDISP_RST = 10'h0ef;
  localparam logic [5:0] VND_RST   = 6'h03;
  localparam logic [4:0] ALT_RST   = 5'h00;

  // ---------------------------------------------------------------------------
  // timing in pixel clock periods
  // ---------------------------------------------------------------------------
  localparam cnt_t LINE_W_TS     = 11'h00b;
  localparam cnt_t FRAME_HOLD_TS = 11'h00c;
  localparam cnt_t ALT_BASE_TS   = 11'h003;
  localparam cnt_t RISE_48_TS    = 11'h012;
  localparam cnt_t RISE_15_TS    = 11'h010;
  localparam cnt_t FALL8_48_TS   = 11'h014;
  localparam cnt_t FALL8_15_TS   = 11'h012;
  localparam cnt_t FALL16_48_TS  = 11'h015;
  localparam cnt_t FALL16_15_TS  = 11'h013;
  localparam cnt_t END8_TS       = 11'h003;
  localparam cnt_t END16_TS      = 11'h005;
  localparam cnt_t PER8_TS       = 11'h002;
  localparam cnt_t PER16_TS      = 11'h005;
  localparam cnt_t HIGH8_TS      = 11'h001;
  localparam cnt_t HIGH16_TS     = 11'h002;
  localparam cnt_t LOAD8_PH      = 11'h001;
  localparam cnt_t LOAD16_PH     = 11'h002;

endpackage

// file: design/stn_fifo.sv
// small first-in first-out buffer between the register bus and the panel
// assumes one clock; reads are show-ahead from the storage registers
`timescale 1ns/1ps
module stn_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_t;

  fifo_t st;
  fifo_t next_st;
  logic  push;
  logic  pop;

  always_comb begin
    next_st   = st;
    in_ready  = (st.cnt != FULL);
    out_valid = (st.cnt != '0);
    out_data  = st.mem[st.rp];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp         = (st.wp == LAST) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == LAST) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// file: design/stn_color_panel_timing.sv
// timing generator for a single-scan colour passive panel, 8-bit or 16-bit path
// assumes an apb master on the system clock; pixel data arrive through the
// data register and are paced out by the panel timing
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - pixel clock is system clock divided 1..4
// - frame pulse rises 12 Ts into last line
// - frame held 12 Ts; line pulse 11 Ts
// - alt drive toggles after programmed line delay
// - 8-bit shift clock period 2, high 1
// - 8-bit data stable 1 Ts around fall
// - first fall at 20 or 21 Ts
// - at 15/16 bpp first fall 18 or 19
// - first rise at 18 or 16 Ts
// - 8-bit last fall to line fall gap
// - 8-bit last fall to line rise gap
// - 16-bit shift clock period 5, high 2
// - 16-bit data stable 2 Ts around fall
// - 16-bit last fall to line fall gap
// - 16-bit last fall to line rise gap
module stn_color_panel_timing #(
  parameter int FIFO_DEPTH = 4,
  parameter int DATA_WIDTH = 16
) (
  // clock and reset
  input  wire logic           CLOCK,
  input  wire logic           ARST_N,
  // apb slave
  input  wire logic           PSEL,
  input  wire logic           PENABLE,
  input  wire logic           PWRITE,
  input  wire stn_pkg::addr_t PADDR,
  input  wire stn_pkg::word_t PWDATA,
  output stn_pkg::word_t      PRDATA,
  output logic                PREADY,
  output logic                PSLVERR,
  // panel
  output logic                FRAME_PULSE,
  output logic                LINE_PULSE,
  output logic                SHIFT_CLOCK,
  output logic [15:0]         PANEL_DATA,
  output logic                ALT_DRIVE_OUT
);
  import stn_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        enable;
    logic        wide;
    logic        bpp15;
    logic [1:0]  div;
    logic [6:0]  hdisp;
    logic [4:0]  hnd;
    logic [9:0]  vdisp;
    logic [5:0]  vnd;
    logic [4:0]  alt_rate;
    logic        underrun;
    run_t        run;
    logic [1:0]  div_cnt;
    cnt_t        hcnt;
    cnt_t        vcnt;
    cnt_t        ph;
    logic        frame;
    logic        line;
    logic        shift;
    logic        alt;
    logic [15:0] data;
    word_t       rdata;
  } state_t;

  state_t                  st;
  state_t                  next_st;
  logic                    tick;
  cnt_t                    hd8;
  cnt_t                    hn8;
  cnt_t                    line_len;
  cnt_t                    vtotal;
  cnt_t                    first_fall;
  cnt_t                    first_rise;
  cnt_t                    period;
  cnt_t                    high;
  cnt_t                    load_ph;
  cnt_t                    win_start;
  cnt_t                    win_end;
  cnt_t                    alt_dly;
  cnt_t                    nh;
  cnt_t                    nv;
  cnt_t                    nph;
  logic                    in_win;
  logic                    load;
  logic                    pop;
  logic                    wr;
  logic                    push;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic [DATA_WIDTH-1:0]   fifo_out_data;

  // ---------------------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------------------
  function automatic cnt_t by_mode(input logic wide, input logic bpp15,
                                   input cnt_t n8_48, input cnt_t n8_15,
                                   input cnt_t n16_48, input cnt_t n16_15);
    cnt_t r;
    case ({wide, bpp15})
      2'b00:   r = n8_48;
      2'b01:   r = n8_15;
      2'b10:   r = n16_48;
      default: r = n16_15;
    endcase
    return r;
  endfunction

  function automatic logic reg_hit(input addr_t a);
    return (a == ADDR_CTRL) || (a == ADDR_HTIME) || (a == ADDR_VTIME) ||
           (a == ADDR_ALT) || (a == ADDR_STATUS) || (a == ADDR_DATA);
  endfunction

  // ---------------------------------------------------------------------------
  // pixel data buffer
  // ---------------------------------------------------------------------------
  stn_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (CLOCK),
    .arst_n    (ARST_N),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (PWDATA[DATA_WIDTH-1:0]),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st    = st;
    tick       = (st.div_cnt == st.div);
    hd8        = (cnt_t'(st.hdisp) + 11'h001) << 3;
    hn8        = (cnt_t'(st.hnd) + 11'h001) << 3;
    line_len   = hd8 + hn8;
    vtotal     = cnt_t'(st.vdisp) + cnt_t'(st.vnd) + 11'h002;
    first_fall = by_mode(st.wide, st.bpp15, FALL8_48_TS, FALL8_15_TS,
                         FALL16_48_TS, FALL16_15_TS);
    first_rise = by_mode(st.wide, st.bpp15, RISE_48_TS, RISE_15_TS,
                         RISE_48_TS, RISE_15_TS);
    period     = st.wide ? PER16_TS : PER8_TS;
    high       = st.wide ? HIGH16_TS : HIGH8_TS;
    load_ph    = st.wide ? LOAD16_PH : LOAD8_PH;
    // the last fall may sit no later than this, which fixes the line-end gaps
    win_end    = hd8 + first_fall - (st.wide ? END16_TS : END8_TS);
    win_start  = first_fall - period;
    alt_dly    = (st.alt_rate == '0) ? ALT_BASE_TS
               : ((cnt_t'(st.alt_rate) + 11'h001) << 3) + ALT_BASE_TS;
    nh         = '0;
    nv         = '0;
    nph        = '0;
    in_win     = 1'b0;
    load       = 1'b0;
    pop        = 1'b0;

    // apb slave: a full data buffer holds the write in its access phase
    push    = PSEL && PENABLE && PWRITE && (PADDR == ADDR_DATA);
    PREADY  = !push || fifo_in_ready;
    PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);
    PRDATA  = st.rdata;
    wr      = PSEL && PENABLE && PWRITE && PREADY && reg_hit(PADDR);
    if (PSEL && !PENABLE) begin
      next_st.rdata = '0;
      case (PADDR)
        ADDR_CTRL: begin
          next_st.rdata[CTRL_EN_BIT]         = st.enable;
          next_st.rdata[CTRL_WIDE_BIT]       = st.wide;
          next_st.rdata[CTRL_BPP15_BIT]      = st.bpp15;
          next_st.rdata[CTRL_DIV_LSB +: 2]   = st.div;
        end
        ADDR_HTIME: begin
          next_st.rdata[HT_DISP_LSB +: 7]    = st.hdisp;
          next_st.rdata[HT_ND_LSB +: 5]      = st.hnd;
        end
        ADDR_VTIME: begin
          next_st.rdata[VT_DISP_LSB +: 10]   = st.vdisp;
          next_st.rdata[VT_ND_LSB +: 6]      = st.vnd;
        end
        ADDR_ALT: begin
          next_st.rdata[ALT_RATE_LSB +: 5]   = st.alt_rate;
        end
        ADDR_STATUS: begin
          next_st.rdata[ST_LINE_LSB +: 11]   = st.vcnt;
          next_st.rdata[ST_EMPTY_BIT]        = !fifo_out_valid;
          next_st.rdata[ST_FULL_BIT]         = !fifo_in_ready;
          next_st.rdata[ST_UNDER_BIT]        = st.underrun;
          next_st.rdata[ST_RUN_BIT]          = (st.run == ST_RUN);
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
    if (wr) begin
      case (PADDR)
        ADDR_CTRL: begin
          next_st.enable = PWDATA[CTRL_EN_BIT];
          next_st.wide   = PWDATA[CTRL_WIDE_BIT];
          next_st.bpp15  = PWDATA[CTRL_BPP15_BIT];
          next_st.div    = PWDATA[CTRL_DIV_LSB +: 2];
        end
        ADDR_HTIME: begin
          next_st.hdisp = PWDATA[HT_DISP_LSB +: 7];
          next_st.hnd   = PWDATA[HT_ND_LSB +: 5];
        end
        ADDR_VTIME: begin
          next_st.vdisp = PWDATA[VT_DISP_LSB +: 10];
          next_st.vnd   = PWDATA[VT_ND_LSB +: 6];
        end
        ADDR_ALT: begin
          next_st.alt_rate = PWDATA[ALT_RATE_LSB +: 5];
        end
        ADDR_STATUS: begin
          if (PWDATA[ST_UNDER_BIT]) begin
            next_st.underrun = 1'b0;
          end
        end
        default: begin
          next_st.underrun = st.underrun;
        end
      endcase
    end

    // panel timing
    case (st.run)
      ST_IDLE: begin
        if (st.enable) begin
          next_st.run = ST_RUN;
        end
      end
      ST_RUN: begin
        next_st.div_cnt = tick ? 2'h0 : st.div_cnt + 2'h1;
        if (tick) begin
          if (st.hcnt >= line_len - 11'h001) begin
            nh = '0;
            nv = (st.vcnt >= vtotal - 11'h001) ? '0 : st.vcnt + 11'h001;
          end else begin
            nh = st.hcnt + 11'h001;
            nv = st.vcnt;
          end
          nph = (nh == win_start || st.ph >= period - 11'h001) ? '0
              : st.ph + 11'h001;
          // shifting only inside the display part of an active line
          in_win = (nv <= cnt_t'(st.vdisp)) && (nh >= win_start) &&
                   (nh <= win_end);
          next_st.hcnt  = nh;
          next_st.vcnt  = nv;
          next_st.ph    = nph;
          next_st.line  = (nh >= line_len - LINE_W_TS);
          next_st.frame = ((nv == vtotal - 11'h001) && (nh >= FRAME_HOLD_TS)) ||
                          ((nv == '0) && (nh < FRAME_HOLD_TS) && st.frame);
          next_st.shift = in_win && (nh + period - nph <= win_end) &&
                          (((nh >= first_rise) && (nh < first_fall)) ||
                           ((nh >= first_fall) && (nph >= period - high)));
          // new data a fixed phase before each fall keeps setup and hold
          load = in_win && (nph == load_ph) &&
                 (nh + period - load_ph <= win_end);
          if (load) begin
            pop = fifo_out_valid;
            next_st.underrun = st.underrun || !fifo_out_valid;
            if (!fifo_out_valid) begin
              next_st.data = '0;
            end else if (st.wide) begin
              next_st.data = fifo_out_data[15:0];
            end else begin
              next_st.data = {8'h00, fifo_out_data[7:0]};
            end
          end
          if (nh == alt_dly) begin
            next_st.alt = !st.alt;
          end
        end
        if (!st.enable) begin
          next_st.run     = ST_IDLE;
          next_st.div_cnt = '0;
          next_st.hcnt    = '0;
          next_st.vcnt    = '0;
          next_st.ph      = '0;
          next_st.line    = 1'b0;
          next_st.frame   = 1'b0;
          next_st.shift   = 1'b0;
          next_st.alt     = 1'b0;
          next_st.data    = '0;
        end
      end
      default: begin
        next_st.run = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      st          <= '0;
      st.div      <= DIV_RST;
      st.hdisp    <= HDISP_RST;
      st.hnd      <= HND_RST;
      st.vdisp    <= VDISP_RST;
      st.vnd      <= VND_RST;
      st.alt_rate <= ALT_RST;
      st.run      <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign FRAME_PULSE   = st.frame;
  assign LINE_PULSE    = st.line;
  assign SHIFT_CLOCK   = st.shift;
  assign PANEL_DATA    = st.data;
  assign ALT_DRIVE_OUT = st.alt;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_pair_ticks;
    !tick ##1 tick;
  endsequence

  a_tick_spacing: assert property (
    disable iff (!ARST_N || !st.enable)
    (st.run == ST_RUN) && tick && (st.div == 2'h1) && $stable(st.div) |=> s_pair_ticks)
    else $error("pixel tick spacing wrong for divide by two");
  a_line_period: assert property (
    $fell(LINE_PULSE) && (st.run == ST_RUN) |->
      (st.hcnt == '0) && ($past(st.hcnt) == line_len - 11'h001))
    else $error("line pulse fell off the line boundary");
  a_frame_lines: assert property (
    $rose(FRAME_PULSE) |-> (st.vcnt == vtotal - 11'h001))
    else $error("frame pulse not in last line of frame");
  a_frame_lead: assert property (
    $rose(FRAME_PULSE) |-> (st.hcnt == FRAME_HOLD_TS))
    else $error("frame pulse lead wrong");
  a_frame_hold: assert property (
    $fell(FRAME_PULSE) && (st.run == ST_RUN) |->
      (st.vcnt == '0) && (st.hcnt == FRAME_HOLD_TS))
    else $error("frame pulse hold wrong");
  a_line_width: assert property (
    $rose(LINE_PULSE) |-> (st.hcnt == line_len - LINE_W_TS))
    else $error("line pulse width wrong");
  a_alt_delay: assert property (
    $changed(ALT_DRIVE_OUT) && (st.run == ST_RUN) |-> (st.hcnt == alt_dly))
    else $error("alternate drive toggled at wrong delay");
  a_first_rise: assert property (
    $rose(SHIFT_CLOCK) && (st.hcnt < first_fall) |-> (st.hcnt == first_rise))
    else $error("first shift rise misplaced");
  a_fall_phase: assert property (
    $fell(SHIFT_CLOCK) && (st.run == ST_RUN) |->
      (st.ph == '0) && (st.hcnt >= first_fall) && (st.hcnt <= win_end))
    else $error("shift fall off its phase or outside the window");
  a_high_phase: assert property (
    $rose(SHIFT_CLOCK) && (st.hcnt > first_fall) |-> (st.ph == period - high))
    else $error("shift high time wrong");
  a_data_stable: assert property (
    $fell(SHIFT_CLOCK) && (st.run == ST_RUN) |-> $stable(PANEL_DATA))
    else $error("panel data changed at a shift fall");
  a_idle_shift: assert property (
    (st.vcnt > cnt_t'(st.vdisp)) |-> !SHIFT_CLOCK)
    else $error("shift clock active in non-display line");

endmodule

// file: verif/panel_model.sv
// panel model: times line, frame and alt edges, shift falls and the first shift rise from the last line pulse fall
// assumes registered panel outputs, sampled on the system clock
`timescale 1ns/1ps
module panel_model (
  // clock
  input wire logic        clock,
  // panel pins
  input wire logic        frame_pulse,
  input wire logic        line_pulse,
  input wire logic        shift_clock,
  input wire logic [15:0] panel_data,
  input wire logic        alt_drive_out
);
  // ---------------------------------------------------------------------------
  // edge times in system clocks
  // ---------------------------------------------------------------------------
  int          cyc, lrise, lw, lper, rise1, fall1, lastf, sper, gapf, gapr, frise, lead;
  int          foff, aoff, lines, nlines, frames, nf, nfl, fcnt, ffr;
  bit          gotr, gotf;
  logic        lp, sp, fp, ap;
  logic [15:0] seen[$];
  always @(posedge clock) begin
    cyc++;
    if (!lp && line_pulse) begin
      lrise = cyc;
      if (gotf) gapr = cyc - lastf;
    end
    if (lp && !line_pulse) begin
      lw = cyc - lrise;
      lper = cyc;
      lead = cyc - frise;
      if (gotf) gapf = cyc - lastf;
      if (nf > 0) nfl = nf;
      nf = 0;
      cyc = 0;
      frise = 0;
      gotr = 0;
      gotf = 0;
      lines++;
    end
    if (!sp && shift_clock && !gotr) begin
      rise1 = cyc;
      gotr = 1;
    end
    if (sp && !shift_clock) begin
      // data still held in the sample where the fall first shows
      if (!gotf) fall1 = cyc;
      else sper = cyc - lastf;
      gotf = 1;
      lastf = cyc;
      nf++;
      fcnt++;
      seen.push_back(panel_data);
    end
    if (!fp && frame_pulse) begin
      frise = cyc;
      nlines = lines;
      lines = 0;
      ffr = fcnt;
      fcnt = 0;
      frames++;
    end
    if (fp && !frame_pulse) foff = cyc;
    if (ap != alt_drive_out) aoff = cyc;
    lp = line_pulse;
    sp = shift_clock;
    fp = frame_pulse;
    ap = alt_drive_out;
  end
endmodule

// file: verif/tb.sv
// testbench: register access, buffer fill and drain, timed panel runs
// assumes the panel model counts edge times in system clocks
`timescale 1ns/1ps
module tb;
  import stn_pkg::*;
  // ---------------------------------------------------------------------------
  // stimulus and design
  // ---------------------------------------------------------------------------
  logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  addr_t       paddr = '0;
  word_t       pwdata = '0, prdata;
  logic        pready, pslverr, frame_p, line_p, shift_c, alt_d;
  logic [15:0] pdata;
  int          bad_count = 0, n_checks = 0;
  always #25 clock = ~clock;
  stn_color_panel_timing dut (.CLOCK(clock), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FRAME_PULSE(frame_p), .LINE_PULSE(line_p), .SHIFT_CLOCK(shift_c),
    .PANEL_DATA(pdata), .ALT_DRIVE_OUT(alt_d));
  panel_model pm (.clock(clock), .frame_pulse(frame_p), .line_pulse(line_p),
    .shift_clock(shift_c), .panel_data(pdata), .alt_drive_out(alt_d));
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      bad_count++;
      $display("ERROR %0t: measured %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input addr_t a, input word_t d, output word_t q,
                     output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input addr_t a, input word_t d);
    word_t q;
    logic  e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input addr_t a, input word_t exp);
    word_t q;
    logic  e;
    apb(1'b0, a, '0, q, e);
    chk(q, exp);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    word_t q;
    logic  e;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_HTIME, {19'h0, HND_RST, 1'b0, HDISP_RST});
    rd(ADDR_VTIME, {10'h0, VND_RST, 6'h0, VDISP_RST});
    rd(ADDR_ALT, {27'h0, ALT_RST});
    rd(ADDR_DATA, 32'h0);
    apb(1'b0, 8'h18, '0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask
  task automatic t_fifo();
    wr(ADDR_DATA, 32'h00a5);
    wr(ADDR_DATA, 32'h0011);
    wr(ADDR_DATA, 32'h0022);
    wr(ADDR_DATA, 32'h0033);
    rd(ADDR_STATUS, 32'h1 << ST_FULL_BIT);
  endtask
  task automatic t_drain();
    rd(ADDR_STATUS, (32'h1 << ST_EMPTY_BIT) | (32'h1 << ST_UNDER_BIT));
    wr(ADDR_STATUS, 32'h1 << ST_UNDER_BIT);
    rd(ADDR_STATUS, 32'h1 << ST_EMPTY_BIT);
  endtask
  // hdisp 3, hnd 4: 72 Ts lines; vdisp 1, vnd 0: three lines a frame
  task automatic t_run(input logic wide, b15, input logic [1:0] dv, input logic [4:0] rt,
                       input logic [15:0] w, input logic fill);
    int m, fo, gf, t;
    word_t q;
    logic  e;
    m = dv + 1;
    fo = wide ? (b15 ? 19 : 21) : (b15 ? 18 : 20);
    gf = 40 - (wide ? (b15 ? 14 : 16) : (b15 ? 15 : 17));
    if (fill) wr(ADDR_DATA, {16'h0, w});
    wr(ADDR_HTIME, 32'h0403);
    wr(ADDR_VTIME, 32'h0001);
    wr(ADDR_ALT, {27'h0, rt});
    pm.seen.delete();
    wr(ADDR_CTRL, {26'h0, dv, 1'b0, b15, wide, 1'b1});
    t = pm.frames + 3;
    for (int i = 0; i < 5000 && pm.frames < t; i++) @(posedge clock);
    // the frame lead is only measured at the line fall that follows the frame rise
    for (int i = 0; i < 500 && pm.lines == 0; i++) @(posedge clock);
    chk_n(pm.frames >= t && pm.lines > 0, 1);
    chk_n(pm.lper, 72 * m);
    chk_n(pm.nlines, 3);
    chk_n(pm.lead, 60 * m);
    chk_n(pm.foff, 12 * m);
    chk_n(pm.lw, 11 * m);
    chk_n(pm.aoff, (rt == 0 ? 3 : (rt + 1) * 8 + 3) * m);
    chk_n(pm.sper, (wide ? 5 : 2) * m);
    chk_n(pm.rise1, (b15 ? 16 : 18) * m);
    chk_n(pm.fall1, fo * m);
    chk_n(pm.gapf >= gf * m && pm.gapf < (gf + (wide ? 5 : 2)) * m, 1);
    chk_n(pm.gapr, pm.gapf - 11 * m);
    chk_n(pm.ffr, 2 * pm.nfl);
    chk({16'h0, pm.seen[0]}, {16'h0, wide ? w : {8'h0, w[7:0]}});
    apb(1'b0, ADDR_STATUS, '0, q, e);
    chk({30'h0, q[ST_RUN_BIT], e}, 32'h2);
    wr(ADDR_CTRL, 32'h0);
  endtask
  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_fifo();
    t_run(1'b0, 1'b0, 2'd0, 5'd0, 16'h00a5, 1'b0);
    t_drain();
    t_run(1'b1, 1'b1, 2'd1, 5'd1, 16'h5a3c, 1'b1);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
endmodule
